// ### common/hpp_pkg.sv
// constants, carriers and states shared by the host processor port
package hpp_pkg;

  localparam int HPP_ADDR_W = 13;
  localparam int HPP_DATA_W = 8;
  localparam int HPP_SHORT_ADDR_W = 5;
  localparam int HPP_FIRST_FIELD_W = 6;

  // strap positions on the data bus
  localparam int HPP_STRAP_CPOL_POS = 7;
  localparam int HPP_STRAP_CPHA_POS = 6;
  localparam int HPP_STRAP_SWAP_POS = 5;

  // control byte layout in stream order
  localparam int HPP_CTL_RW_POS = 7;
  localparam int HPP_CTL_EXT_POS = 6;
  localparam int HPP_CTL_BURST_POS = 0;

  // serial bit counter landmarks
  localparam logic [2:0] HPP_BIT_FIRST = 3'h0;
  localparam logic [2:0] HPP_BIT_ADDR_DONE = 3'h6;
  localparam logic [2:0] HPP_BIT_LAST = 3'h7;

  // cycles after reset release until straps are final
  localparam logic [1:0] HPP_STRAP_SETTLE = 2'h3;

  // level meaning read on direction line and read flag
  localparam logic HPP_DIR_READ = 1'b1;

  typedef struct packed {
    logic rw;
    logic [HPP_ADDR_W-1:0] addr;
    logic [HPP_DATA_W-1:0] data;
  } hpp_req_t;

  typedef struct packed {
    logic serial;
    logic motorola;
    logic cpol;
    logic cpha;
    logic lsb_first;
  } hpp_strap_t;

  localparam hpp_strap_t HPP_STRAP_RST = '0;
  localparam hpp_req_t HPP_REQ_RST = '0;

  typedef enum logic [2:0] {
    HPP_CTL_FIRST = 3'b001,
    HPP_CTL_SECOND = 3'b010,
    HPP_DATA = 3'b100
  } hpp_spi_state_t;

endpackage

// ### rtl/hpp_sync.sv
// two-flop synchroniser for pin levels and toggles
module hpp_sync
  import hpp_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  // stage1 feeds only the second flop, never other logic
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      stage1 <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule // hpp_sync

// ### rtl/hpp_regmem.sv
// byte-wide register space with registered read data
module hpp_regmem
  import hpp_pkg::*;
#(
  parameter int ADDR_W = HPP_ADDR_W,
  parameter int DATA_W = HPP_DATA_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // access port
  input wire logic re,
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // array has no reset; software initialises the space itself
  always_ff @(posedge clk)
  begin
    if (we)
      mem[addr] <= wdata;
  end

  // read data only moves on a read, so it stays stable for slow takers
  always_ff @(posedge clk)
  begin
    if (!resetn)
      rdata <= '0;
    else if (re)
      rdata <= mem[addr];
  end

endmodule // hpp_regmem

// ### rtl/hpp_top.sv
// host processor port: parallel bus, serial slave and register space
module hpp_top
  import hpp_pkg::*;
#(
  parameter int IRQ_N = 8
)
(
  // system
  input wire logic clk_sys,
  input wire logic resetn,
  // parallel bus pins
  input wire logic port_select_low,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic [HPP_ADDR_W-1:0] addr_in,
  input wire logic [HPP_DATA_W-1:0] data_in,
  output logic [HPP_DATA_W-1:0] data_out,
  output logic data_oe,
  // strap pins
  input wire logic bus_style_strap,
  input wire logic serial_select_strap,
  // serial link
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // interrupt conditions and open-drain pin
  input wire logic [IRQ_N-1:0] irq_cond,
  input wire logic [IRQ_N-1:0] irq_enable,
  output logic irq_out_low,
  output logic irq_out_low_oe,
  // status
  output hpp_strap_t strap_state,
  output logic strap_ready
);

  localparam int PIN_W = 5 + HPP_ADDR_W + HPP_DATA_W;
  localparam logic [PIN_W-1:0] PIN_RST = {3'h7, 2'h0, {HPP_ADDR_W{1'b0}}, {HPP_DATA_W{1'b0}}};

  // ---------------- system domain: pins ----------------
  logic [PIN_W-1:0] pins_sync;
  logic sel_low_s;
  logic rd_pin_s;
  logic wr_pin_s;
  logic style_s;
  logic serial_s;
  logic [HPP_ADDR_W-1:0] addr_s;
  logic [HPP_DATA_W-1:0] data_s;

  // every bus and strap pin passes two flops; strobes reset to their idle high level
  hpp_sync #(
    .WIDTH(PIN_W),
    .RST_VAL(PIN_RST)
  ) u_pin_sync (
    .clk(clk_sys),
    .resetn(resetn),
    .din({port_select_low, read_strobe_low, write_strobe_low, bus_style_strap,
          serial_select_strap, addr_in, data_in}),
    .dout(pins_sync)
  );

  assign {sel_low_s, rd_pin_s, wr_pin_s, style_s, serial_s, addr_s, data_s} = pins_sync;

  // ---------------- straps ----------------
  logic [1:0] strap_cnt;

  // straps follow the synchronised pins until settled, then freeze
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      strap_cnt <= '0;
      strap_state <= HPP_STRAP_RST;
    end
    else if (strap_cnt != HPP_STRAP_SETTLE)
    begin
      strap_cnt <= strap_cnt + 2'h1;
      strap_state.serial <= serial_s;
      strap_state.motorola <= style_s;
      strap_state.cpol <= data_s[HPP_STRAP_CPOL_POS];
      strap_state.cpha <= data_s[HPP_STRAP_CPHA_POS];
      strap_state.lsb_first <= data_s[HPP_STRAP_SWAP_POS];
    end
  end

  assign strap_ready = (strap_cnt == HPP_STRAP_SETTLE);

  // ---------------- parallel bus decode ----------------
  wire par_on = strap_ready & ~strap_state.serial;
  wire sel_act = par_on & ~sel_low_s;
  // intel style: one strobe per direction
  wire intel_rd = ~strap_state.motorola & sel_act & ~rd_pin_s;
  wire intel_wr = ~strap_state.motorola & sel_act & ~wr_pin_s;
  // motorola style: read pin is the data strobe, write pin the direction line
  wire moto_ds = strap_state.motorola & sel_act & ~rd_pin_s;
  wire moto_rd = moto_ds & (wr_pin_s == HPP_DIR_READ);
  wire moto_wr = moto_ds & (wr_pin_s != HPP_DIR_READ);
  wire par_rd = intel_rd | moto_rd;
  wire par_wr = intel_wr | moto_wr;

  logic par_rd_q;
  logic par_wr_q;
  logic [HPP_ADDR_W-1:0] par_addr;
  logic [HPP_DATA_W-1:0] par_data;

  // address and data on their own lines, captured while a strobe is active and held after it
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      par_rd_q <= 1'b0;
      par_wr_q <= 1'b0;
      par_addr <= '0;
      par_data <= '0;
    end
    else
    begin
      par_rd_q <= par_rd;
      par_wr_q <= par_wr;
      if (par_rd | par_wr)
      begin
        par_addr <= addr_s;
        par_data <= data_s;
      end
    end
  end

  // read starts on strobe entry; write commits on strobe exit with held values
  wire par_rd_start = par_rd & ~par_rd_q;
  wire par_wr_end = ~par_wr & par_wr_q;

  // ---------------- serial requests into system domain ----------------
  hpp_req_t link_req;
  logic link_tgl;
  logic tgl_s;
  logic tgl_seen;

  hpp_sync #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_tgl_sync (
    .clk(clk_sys),
    .resetn(resetn),
    .din(link_tgl),
    .dout(tgl_s)
  );

  // the request word is stable once its toggle has crossed
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      tgl_seen <= 1'b0;
    else
      tgl_seen <= tgl_s;
  end

  wire spi_go = strap_ready & strap_state.serial & (tgl_s ^ tgl_seen);

  // ---------------- register space ----------------
  logic [HPP_DATA_W-1:0] mem_rdata;
  wire mem_re = strap_state.serial ? (spi_go & (link_req.rw == HPP_DIR_READ)) : par_rd_start;
  wire mem_we = strap_state.serial ? (spi_go & (link_req.rw != HPP_DIR_READ)) : par_wr_end;
  wire [HPP_ADDR_W-1:0] mem_addr = strap_state.serial ? link_req.addr : (par_rd_start ? addr_s : par_addr);
  wire [HPP_DATA_W-1:0] mem_wdata = strap_state.serial ? link_req.data : par_data;

  hpp_regmem #(
    .ADDR_W(HPP_ADDR_W),
    .DATA_W(HPP_DATA_W)
  ) u_regmem (
    .clk(clk_sys),
    .resetn(resetn),
    .re(mem_re),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // read data drives the bus only while a read strobe is active
  assign data_out = mem_rdata;
  assign data_oe = par_rd;

  // ---------------- interrupt pin ----------------
  logic irq_pend;

  // open drain: value fixed low, only the enable moves
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      irq_pend <= 1'b0;
    else
      irq_pend <= |(irq_cond & irq_enable);
  end

  assign irq_out_low = 1'b0;
  assign irq_out_low_oe = irq_pend;

  // ---------------- link domain ----------------
  // one rising edge samples in every mode; the other edge launches
  wire spi_clk_s = spi_sclk ^ (strap_state.cpol ^ strap_state.cpha);
  // select high clears the frame state, so the next byte is control
  wire frame_rst = port_select_low | ~resetn | ~strap_state.serial;
  wire link_rst = ~resetn;

  hpp_spi_state_t state;
  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic [HPP_FIRST_FIELD_W-1:0] first_ctl;
  logic is_rd;
  logic burst;
  logic [HPP_ADDR_W-1:0] cur_addr;
  logic [HPP_DATA_W-1:0] out_sh;

  wire [7:0] byte_now = {shift_in, spi_mosi};
  wire [6:0] byte7 = {shift_in[5:0], spi_mosi};
  wire [HPP_SHORT_ADDR_W-1:0] short_field = byte7[4:0];
  wire [HPP_ADDR_W-1:0] long_field = {first_ctl, byte7};
  wire [HPP_SHORT_ADDR_W-1:0] short_rev = {<<{short_field}};
  wire [HPP_ADDR_W-1:0] long_rev = {<<{long_field}};
  // in control bytes only address bits follow the order strap; flag bits sit outside the field
  wire [HPP_SHORT_ADDR_W-1:0] short_addr = strap_state.lsb_first ? short_rev : short_field;
  wire [HPP_ADDR_W-1:0] long_addr = strap_state.lsb_first ? long_rev : long_field;
  wire [HPP_ADDR_W-1:0] addr_now = (state == HPP_CTL_FIRST) ? {8'h00, short_addr} : long_addr;
  wire [HPP_DATA_W-1:0] data_rev = {<<{byte_now}};
  wire [HPP_DATA_W-1:0] wr_byte = strap_state.lsb_first ? data_rev : byte_now;
  wire [HPP_ADDR_W-1:0] addr_inc = cur_addr + 13'h0001;

  // address complete one bit before the burst flag
  wire at_addr = (bit_cnt == HPP_BIT_ADDR_DONE);
  wire at_last = (bit_cnt == HPP_BIT_LAST);
  wire addr_done = at_addr & (((state == HPP_CTL_FIRST) & ~byte7[HPP_CTL_EXT_POS-1])
                   | (state == HPP_CTL_SECOND));
  wire addr_rd = (state == HPP_CTL_FIRST) ? (byte7[HPP_CTL_RW_POS-1] == HPP_DIR_READ) : is_rd;
  // reads are fetched early so the byte is ready at the first launch edge
  wire ctl_read_fire = addr_done & addr_rd;
  wire burst_prefetch = (state == HPP_DATA) & (bit_cnt == HPP_BIT_FIRST) & is_rd & burst;
  wire write_fire = (state == HPP_DATA) & at_last & ~is_rd;

  // sample edge: byte assembly and access sequencing
  always_ff @(posedge spi_clk_s or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      state <= HPP_CTL_FIRST;
      bit_cnt <= HPP_BIT_FIRST;
      shift_in <= '0;
      first_ctl <= '0;
      is_rd <= 1'b0;
      burst <= 1'b0;
      cur_addr <= '0;
    end
    else
    begin
      bit_cnt <= bit_cnt + 3'h1;
      shift_in <= byte_now[6:0];
      if (addr_done)
        cur_addr <= addr_now;
      if (at_last)
      begin
        case (state)
          HPP_CTL_FIRST:
          begin
            is_rd <= (byte_now[HPP_CTL_RW_POS] == HPP_DIR_READ);
            if (byte_now[HPP_CTL_EXT_POS])
            begin
              first_ctl <= byte_now[HPP_FIRST_FIELD_W-1:0];
              state <= HPP_CTL_SECOND;
            end
            else
            begin
              burst <= byte_now[HPP_CTL_BURST_POS];
              state <= HPP_DATA;
            end
          end
          HPP_CTL_SECOND:
          begin
            burst <= byte_now[HPP_CTL_BURST_POS];
            state <= HPP_DATA;
          end
          HPP_DATA:
          begin
            // select may stay low: burst keeps data, otherwise control follows
            if (burst)
              cur_addr <= addr_inc;
            else
              state <= HPP_CTL_FIRST;
          end
          default:
            state <= HPP_CTL_FIRST;
        endcase
      end
    end
  end

  // request word and toggle outlive the frame, so only system reset clears them
  always_ff @(posedge spi_clk_s or posedge link_rst)
  begin
    if (link_rst)
    begin
      link_req <= HPP_REQ_RST;
      link_tgl <= 1'b0;
    end
    else if (~port_select_low & strap_state.serial)
    begin
      if (ctl_read_fire)
      begin
        link_req <= '{rw: HPP_DIR_READ, addr: addr_now, data: 8'h00};
        link_tgl <= ~link_tgl;
      end
      else if (burst_prefetch)
      begin
        link_req <= '{rw: HPP_DIR_READ, addr: addr_inc, data: 8'h00};
        link_tgl <= ~link_tgl;
      end
      else if (write_fire)
      begin
        link_req <= '{rw: ~HPP_DIR_READ, addr: cur_addr, data: wr_byte};
        link_tgl <= ~link_tgl;
      end
    end
  end

  // launch edge: read byte is loaded before the first data bit, then shifted
  // the fetched byte is quiet for many system cycles, so it is taken as is
  always_ff @(negedge spi_clk_s or posedge frame_rst)
  begin
    if (frame_rst)
      out_sh <= '0;
    else if ((state == HPP_DATA) & (bit_cnt == HPP_BIT_FIRST))
      out_sh <= strap_state.lsb_first ? {<<{mem_rdata}} : mem_rdata;
    else
      out_sh <= {out_sh[6:0], 1'b0};
  end

  assign spi_miso = out_sh[7];
  assign spi_miso_oe = strap_state.serial & ~port_select_low;

endmodule // hpp_top

// ### tb/hpp_chk.sv
// checker on the pins of the host processor port
module hpp_chk
  import hpp_pkg::*;
#(
  parameter int IRQ_N = 8
)
(
  // system
  input wire logic clk_sys,
  input wire logic resetn,
  // parallel bus
  input wire logic port_select_low,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic data_oe,
  // serial and interrupt
  input wire logic spi_miso_oe,
  input wire logic [IRQ_N-1:0] irq_cond,
  input wire logic [IRQ_N-1:0] irq_enable,
  input wire logic irq_out_low,
  input wire logic irq_out_low_oe,
  // straps
  input wire hpp_strap_t strap_state,
  input wire logic strap_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // pin follows the masked conditions one cycle later
  property p_irq; $past(resetn) |-> irq_out_low_oe == |$past(irq_cond & irq_enable); endproperty
  a_irq: assert property (p_irq) else $error("irq pin wrong");
  property p_irq_od; irq_out_low == 1'h0; endproperty
  a_irq_od: assert property (p_irq_od) else $error("irq not open drain");
  property p_miso_oe; strap_ready |-> spi_miso_oe == (strap_state.serial && !port_select_low); endproperty
  a_miso_oe: assert property (p_miso_oe) else $error("miso drive wrong");
  property p_ser_quiet; strap_state.serial |-> !data_oe; endproperty
  a_ser_quiet: assert property (p_ser_quiet) else $error("bus driven in serial mode");
  // a read drive needs select, read type and strobe seen through the sync
  property p_rd_intel;
    !strap_state.motorola && $rose(data_oe) |-> $past(!port_select_low && write_strobe_low && !read_strobe_low, 2);
  endproperty
  a_rd_intel: assert property (p_rd_intel) else $error("drive without read");
  property p_rd_moto;
    strap_state.motorola && $rose(data_oe) |-> $past(!port_select_low && write_strobe_low && !read_strobe_low, 2);
  endproperty
  a_rd_moto: assert property (p_rd_moto) else $error("drive without read");
  // drive follows the strobe through the two sync flops, so look two edges back
  property p_oe_off; $past(read_strobe_low, 2) |-> !data_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus held after strobe");
  property p_strap_rdy; $rose(resetn) |-> !strap_ready ##[1:4] strap_ready; endproperty
  a_strap_rdy: assert property (p_strap_rdy) else $error("straps not frozen");
  property p_strap_hold; strap_ready && $past(strap_ready) |-> $stable(strap_state); endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("straps moved");
endmodule // hpp_chk

bind hpp_top hpp_chk #(.IRQ_N(IRQ_N)) i_hpp_chk
(
  .clk_sys, .resetn, .port_select_low, .read_strobe_low, .write_strobe_low, .data_oe, .spi_miso_oe,
  .irq_cond, .irq_enable, .irq_out_low, .irq_out_low_oe, .strap_state, .strap_ready
);

// ### tb/hpp_host.sv
// host serial master model driving the link pins
module hpp_host
(
  // clock type the master produces
  input wire logic cpol,
  input wire logic cpha,
  // link pins
  input wire logic miso,
  output logic sclk,
  output logic mosi,
  output logic sel_low
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: deselected, clock parked
  initial
  begin
    sclk = 1'h0;
    mosi = 1'h0;
    sel_low = 1'h1;
  end
  // offset keeps the link clock out of phase with the system clock
  task automatic open_f();
    // park the clock while still deselected, so no edge lands inside the frame
    #13.3 sclk = cpol;
    #8 sel_low = 1'h0;
    #24;
  endtask
  // released data line flips so a stale level never passes
  task automatic close_f();
    #32 sel_low = 1'h1;
    mosi = ~mosi;
  endtask
  // one byte, first bit of tx first on the wire
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      if (cpha)
        sclk = ~cpol;
      mosi = tx[i];
      #32 sclk = cpha ? cpol : ~cpol;
      rx[i] = miso;
      #32 sclk = cpol;
    end
  endtask
endmodule // hpp_host

// ### tb/tb_top.sv
// self-checking bench for the host processor port
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin failures++; $display("[FAIL] %0t %s", $time, m); end end
module tb_top
  import hpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  int failures = 0;
  int num_checks = 0;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic p_sel = 1'h1;
  logic read_strobe_low = 1'h1;
  logic write_strobe_low = 1'h1;
  logic [HPP_ADDR_W-1:0] addr_in = '0;
  logic [7:0] p_d = 8'h00;
  logic bus_style_strap = 1'h0;
  logic serial_select_strap = 1'h0;
  logic [7:0] irq_cond = 8'h00;
  logic [7:0] irq_enable = 8'h00;
  logic lsb = 1'h0;
  wire [7:0] data_in, data_out;
  wire data_oe, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, h_sel, h_miso, port_select_low;
  wire irq_out_low, irq_out_low_oe, strap_ready, irq_n;
  hpp_strap_t strap_state;
  always #2 clk_sys = ~clk_sys;
  // pin levels as every party sees them
  assign data_in = data_oe ? data_out : p_d;
  assign port_select_low = serial_select_strap ? h_sel : p_sel;
  assign h_miso = spi_miso_oe ? spi_miso : ~spi_miso;
  assign irq_n = irq_out_low_oe ? irq_out_low : 1'h1; // pull-up
  hpp_top i_hpp_top (.clk_sys, .resetn, .port_select_low, .read_strobe_low, .write_strobe_low, .addr_in,
    .data_in, .data_out, .data_oe, .bus_style_strap, .serial_select_strap, .spi_sclk, .spi_mosi, .spi_miso,
    .spi_miso_oe, .irq_cond, .irq_enable, .irq_out_low, .irq_out_low_oe, .strap_state, .strap_ready);
  hpp_host i_hpp_host (.cpol(p_d[7]), .cpha(p_d[6]), .miso(h_miso), .sclk(spi_sclk), .mosi(spi_mosi),
    .sel_low(h_sel));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // reset with straps on the pins, then wait for them to freeze
  task automatic rst(input logic ser, moto, input logic [2:0] st);
    int n;
    resetn = 1'h0;
    serial_select_strap = ser;
    bus_style_strap = moto;
    p_d = {st, 5'h00};
    lsb = st[0];
    tick(3);
    resetn = 1'h1;
    for (n = 0; n < 20 && strap_ready !== 1'h1; n++)
      tick(1);
    if (n == 20)
    begin
      failures++;
      complete_run();
    end
    tick(6);
    `CHK(strap_state, {ser, moto, st}, "straps")
  endtask
  // one parallel cycle; the strobe pattern is picked by the bus style input moto
  task automatic par(input logic moto, rd, input logic [12:0] a, input logic [7:0] d);
    addr_in = a;
    p_d = d;
    p_sel = 1'h0;
    write_strobe_low = rd;
    read_strobe_low = ~(rd | moto);
    tick(8);
    `CHK(data_oe, rd, "bus drive")
    if (rd)
      `CHK(data_out, d, "read data")
    p_sel = 1'h1;
    read_strobe_low = 1'h1;
    write_strobe_low = moto ? rd : 1'h1;
    tick(6);
  endtask
  // one serial access inside an open frame
  task automatic acc(input logic rw, ext, b, input logic [12:0] a, input logic [7:0] d);
    logic [7:0] rx;
    logic [4:0] s;
    logic [7:0] w;
    s = a[4:0];
    w = d;
    if (lsb)
    begin
      s = {<<{s}};
      w = {<<{w}};
    end
    if (ext)
    begin
      i_hpp_host.xb({rw, 1'h1, a[12:7]}, rx);
      i_hpp_host.xb({a[6:0], b}, rx);
    end
    else
      i_hpp_host.xb({rw, 1'h0, s, b}, rx);
    i_hpp_host.xb(rw ? 8'h00 : w, rx);
    if (lsb)
      rx = {<<{rx}};
    if (rw)
      `CHK(rx, d, "serial read")
  endtask
  task automatic t_irq();
    logic [15:0] tbl [3] = '{16'h1010, 16'h10ef, 16'h00ff};
    foreach (tbl[i])
    begin
      {irq_cond, irq_enable} = tbl[i];
      tick(2);
      `CHK(irq_n, ~|(tbl[i][15:8] & tbl[i][7:0]), "irq pin")
    end
    $display("test irq done");
  endtask
  task automatic t_intel();
    par(1'h0, 1'h0, 13'h1234, 8'h5a);
    par(1'h0, 1'h0, 13'h1fff, 8'hc3);
    par(1'h0, 1'h1, 13'h1234, 8'h5a);
    $display("test intel done");
  endtask
  task automatic t_moto();
    par(1'h1, 1'h0, 13'h0007, 8'h3c);
    par(1'h1, 1'h1, 13'h1fff, 8'hc3);
    par(1'h1, 1'h1, 13'h0007, 8'h3c);
    $display("test moto done");
  endtask
  // mode 0: extended read of a bus write, burst, then split accesses
  task automatic t_spi0();
    logic [7:0] rx;
    i_hpp_host.open_f();
    acc(1'h1, 1'h1, 1'h0, 13'h1234, 8'h5a);
    i_hpp_host.close_f();
    i_hpp_host.open_f();
    acc(1'h0, 1'h0, 1'h0, 13'h0005, 8'h96);
    acc(1'h0, 1'h0, 1'h1, 13'h0002, 8'h11);
    i_hpp_host.xb(8'h22, rx);
    i_hpp_host.close_f();
    i_hpp_host.open_f();
    acc(1'h1, 1'h0, 1'h0, 13'h0003, 8'h22);
    acc(1'h1, 1'h0, 1'h0, 13'h0005, 8'h96);
    i_hpp_host.close_f();
    $display("test spi mode0 done");
  endtask
  // mode 3, reversed order, select held over several accesses
  task automatic t_spi3();
    i_hpp_host.open_f();
    acc(1'h1, 1'h0, 1'h0, 13'h0005, 8'h96);
    acc(1'h0, 1'h0, 1'h0, 13'h0004, 8'h4b);
    acc(1'h1, 1'h0, 1'h0, 13'h0004, 8'h4b);
    acc(1'h1, 1'h0, 1'h0, 13'h0002, 8'h11);
    i_hpp_host.close_f();
    $display("test spi mode3 done");
  endtask
  initial
  begin
    rst(1'h0, 1'h0, 3'h0);
    t_irq();
    t_intel();
    rst(1'h0, 1'h1, 3'h0);
    t_moto();
    rst(1'h1, 1'h0, 3'h0);
    t_spi0();
    rst(1'h1, 1'h0, 3'h7);
    t_spi3();
    complete_run();
  end
endmodule // tb_top
